// ==== rtl/gdf_core.sv ====
// gate drive input processing, dead time and fault handling for two channels
`timescale 1ns/100ps
`default_nettype none
module gdf_core #(
    parameter bit HALF_BRIDGE = gdf_pkg::HALF_BRIDGE_DEFAULT,
    parameter int unsigned PRI_REPORT_CYC = gdf_pkg::PRI_REPORT_CYC,
    parameter int unsigned RELEASE_CYC = gdf_pkg::RELEASE_CYC,
    parameter int unsigned PRI_BLOCK_CYC = gdf_pkg::PRI_BLOCK_CYC,
    parameter int unsigned SEC_REPORT_CYC = gdf_pkg::SEC_REPORT_CYC,
    parameter int unsigned SEC_GAP_CYC = gdf_pkg::SEC_GAP_CYC,
    parameter int unsigned SEC_BLOCK_CYC = gdf_pkg::SEC_BLOCK_CYC,
    parameter int unsigned SC_REPORT_CYC = gdf_pkg::SC_REPORT_CYC,
    parameter int unsigned SC_BLOCK_CYC = gdf_pkg::SC_BLOCK_CYC
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic drive_input_a,
    input wire logic drive_input_b_enable,
    input wire logic pri_undervoltage,
    input wire logic sec_undervoltage_a,
    input wire logic sec_undervoltage_b,
    input wire logic short_circuit_a,
    input wire logic short_circuit_b,
    output logic gate_on_a,
    output logic gate_off_a,
    output logic gate_on_b,
    output logic gate_off_b,
    output logic soft_shutdown_a,
    output logic soft_shutdown_b,
    output logic off_at_zero_a,
    output logic off_at_zero_b,
    output logic fault_out_a,
    output logic fault_out_a_oen,
    output logic fault_out_b,
    output logic fault_out_b_oen
);
    gdf_pkg::gdf_pins_t pins_raw;
    gdf_pkg::gdf_pins_t pins_meta;
    gdf_pkg::gdf_pins_t pins;
    logic in_a_prev;
    logic [15:0] dt_cnt;
    logic toggle;
    logic settled;
    logic [1:0] cmd;
    logic pri_start;
    logic pri_low;
    logic pri_blk;
    logic hard_off;
    logic [1:0] uv_start;
    logic [1:0] uv_low;
    logic [1:0] uv_blk;
    logic [1:0] sc_start;
    logic [1:0] sc_low;
    logic [1:0] sc_blk;
    logic [1:0] gon;
    logic [1:0] goff;
    logic [1:0] soft_shutdown;
    logic [1:0] zero;
    logic [15:0] ssd_cnt [2];

    ////////////////////////////////////////////////////////////////////////////
    // every pin input passes two flip-flops before use
    assign pins_raw = '{drive_a: drive_input_a, drive_b_en: drive_input_b_enable,
                        pri_uv: pri_undervoltage,
                        sec_uv: {sec_undervoltage_b, sec_undervoltage_a},
                        short_circuit: {short_circuit_b, short_circuit_a}};

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pins_meta <= '0;
            pins <= '0;
        end else begin
            pins_meta <= pins_raw;
            pins <= pins_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // dead time: count restarts on enable low and on every control edge
    assign toggle = pins.drive_a != in_a_prev;
    assign settled = pins.drive_b_en && (dt_cnt == gdf_pkg::DEAD_CYC) && !toggle;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            in_a_prev <= 1'b0;
            dt_cnt <= 16'h0;
        end else begin
            in_a_prev <= pins.drive_a;
            if (!HALF_BRIDGE || !pins.drive_b_en || toggle) begin
                dt_cnt <= 16'h0;
            end else if (dt_cnt != gdf_pkg::DEAD_CYC) begin
                dt_cnt <= dt_cnt + 16'h1;
            end
        end
    end

    // mode is a build-time setting with no pin behind it
    always_comb begin
        if (HALF_BRIDGE) begin
            cmd[0] = settled && pins.drive_a;
            cmd[1] = settled && !pins.drive_a;
        end else begin
            cmd[0] = pins.drive_a;
            cmd[1] = pins.drive_b_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    gdf_fault_seq #(
        .REPORT_CYC(PRI_REPORT_CYC),
        .GAP_CYC(0),
        .RELEASE_CYC(RELEASE_CYC),
        .BLOCK_CYC(PRI_BLOCK_CYC),
        .PERSIST(1'b1)
    ) u_pri (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .fault(pins.pri_uv),
        .start(pri_start),
        .report_low(pri_low),
        .blocking(pri_blk)
    );

    for (genvar i = 0; i < 2; i++) begin : g_chan
        gdf_fault_seq #(
            .REPORT_CYC(SEC_REPORT_CYC),
            .GAP_CYC(SEC_GAP_CYC),
            .RELEASE_CYC(RELEASE_CYC),
            .BLOCK_CYC(SEC_BLOCK_CYC),
            .PERSIST(1'b1)
        ) u_uv (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .fault(pins.sec_uv[i]),
            .start(uv_start[i]),
            .report_low(uv_low[i]),
            .blocking(uv_blk[i])
        );

        gdf_fault_seq #(
            .REPORT_CYC(SC_REPORT_CYC),
            .GAP_CYC(0),
            .RELEASE_CYC(RELEASE_CYC),
            .BLOCK_CYC(SC_BLOCK_CYC),
            .PERSIST(1'b0)
        ) u_sc (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .fault(pins.short_circuit[i]),
            .start(sc_start[i]),
            .report_low(sc_low[i]),
            .blocking(sc_blk[i])
        );
    end

    assign hard_off = pins.pri_uv || pri_blk;

    ////////////////////////////////////////////////////////////////////////////
    // gate stage: primary fault cuts hard, a secondary fault that starts a report goes through soft shutdown, one that only blocks cuts hard
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            gon <= 2'b00;
            goff <= 2'b11;
            soft_shutdown <= 2'b00;
            zero <= 2'b00;
            ssd_cnt[0] <= 16'h0;
            ssd_cnt[1] <= 16'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (hard_off) begin
                    gon[i] <= 1'b0;
                    goff[i] <= 1'b1;
                    soft_shutdown[i] <= 1'b0;
                    zero[i] <= 1'b0;
                    ssd_cnt[i] <= 16'h0;
                end else if (uv_start[i] || sc_start[i] || ssd_cnt[i] != 16'h0) begin
                    gon[i] <= 1'b0;
                    goff[i] <= 1'b0;
                    soft_shutdown[i] <= 1'b1;
                    zero[i] <= 1'b0;
                    if (uv_start[i] || sc_start[i]) begin
                        ssd_cnt[i] <= gdf_pkg::SSD_CYC - 16'h1;
                    end else begin
                        ssd_cnt[i] <= ssd_cnt[i] - 16'h1;
                    end
                end else if (uv_blk[i] || sc_blk[i]) begin
                    gon[i] <= 1'b0;
                    goff[i] <= 1'b1;
                    soft_shutdown[i] <= 1'b0;
                    zero[i] <= uv_blk[i] && !sc_blk[i];
                end else begin
                    gon[i] <= cmd[i];
                    goff[i] <= !cmd[i];
                    soft_shutdown[i] <= 1'b0;
                    zero[i] <= 1'b0;
                end
            end
        end
    end

    assign gate_on_a = gon[0];
    assign gate_off_a = goff[0];
    assign gate_on_b = gon[1];
    assign gate_off_b = goff[1];
    assign soft_shutdown_a = soft_shutdown[0];
    assign soft_shutdown_b = soft_shutdown[1];
    assign off_at_zero_a = zero[0];
    assign off_at_zero_b = zero[1];

    ////////////////////////////////////////////////////////////////////////////
    // open-drain status: enable low pulls the line to ground, pin value stays 0
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            fault_out_a <= 1'b0;
            fault_out_b <= 1'b0;
            fault_out_a_oen <= 1'b1;
            fault_out_b_oen <= 1'b1;
        end else begin
            fault_out_a <= 1'b0;
            fault_out_b <= 1'b0;
            fault_out_a_oen <= !(pri_low || uv_low[0] || sc_low[0]);
            fault_out_b_oen <= !(pri_low || uv_low[1] || sc_low[1]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    no_overlap_a: assert property (HALF_BRIDGE |-> !(gon[0] && gon[1]))
        else $error("both gates on in half-bridge mode");
    enable_low_a: assert property (HALF_BRIDGE && !pins.drive_b_en |=> !gon[0] && !gon[1])
        else $error("gate on while enable low");
    dead_b_a: assert property (HALF_BRIDGE && $rose(gon[1]) |-> $past(dt_cnt) == gdf_pkg::DEAD_CYC)
        else $error("channel b on before dead time");
    dead_a_a: assert property (HALF_BRIDGE && $rose(gon[0]) |-> $past(dt_cnt) == gdf_pkg::DEAD_CYC)
        else $error("channel a on before dead time");
    rise_off_a: assert property (HALF_BRIDGE && $rose(pins.drive_a) |=> !gon[1])
        else $error("channel b not cut on control rise");
    fall_off_a: assert property (HALF_BRIDGE && $fell(pins.drive_a) |=> !gon[0])
        else $error("channel a not cut on control fall");
    follow_en_a: assert property (HALF_BRIDGE && !hard_off && !uv_blk[0] && !sc_blk[0]
        && ssd_cnt[0] == 16'h0 && !uv_start[0] && !sc_start[0] && settled && pins.drive_a
        |=> gon[0]) else $error("channel a not following control");
    direct_a: assert property (!HALF_BRIDGE && !hard_off && !uv_blk[1] && !sc_blk[1]
        && ssd_cnt[1] == 16'h0 && !uv_start[1] && !sc_start[1] |=> gon[1] == $past(pins.drive_b_en))
        else $error("direct mode channel b wrong");
    pri_cut_a: assert property ($rose(pins.pri_uv) |=> goff == 2'b11 && gon == 2'b00 && soft_shutdown == 2'b00)
        else $error("primary fault not a hard cut");
    pri_report_a: assert property (pri_start |-> ##2 !fault_out_a_oen && !fault_out_b_oen)
        else $error("primary fault not reported on both lines");
    ssd_first_a: assert property (sc_start[0] && !hard_off |=> soft_shutdown[0] && !gon[0])
        else $error("short circuit without soft shutdown");
    pin_low_a: assert property (fault_out_a == 1'b0 && fault_out_b == 1'b0)
        else $error("status pin driven high");

    cover_dead_c: cover property (HALF_BRIDGE && $rose(gon[1]));
    cover_pri_c: cover property (pri_start ##1 pri_low);
    cover_sc_c: cover property (sc_start[0] ##1 soft_shutdown[0]);
    cover_uv_c: cover property (uv_start[1] ##1 soft_shutdown[1]);
endmodule
`default_nettype wire

// ==== rtl/gdf_pkg.sv ====
// package: constants, carriers and states of the gate drive input and fault logic
`default_nettype none
package gdf_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned DEAD_TIME_NS = 4000;
    localparam logic [15:0] DEAD_CYC = 16'((DEAD_TIME_NS * 125 + 999) / 1000);
    localparam int unsigned SSD_TIME_NS = 2000;
    localparam logic [15:0] SSD_CYC = 16'((SSD_TIME_NS * 125 + 999) / 1000);
    localparam int unsigned PRI_REPORT_MS = 40;
    localparam int unsigned RELEASE_MS = 80;
    localparam int unsigned PRI_BLOCK_MS = 80;
    localparam int unsigned SEC_REPORT_MS = 20;
    localparam int unsigned SEC_GAP_MS = 100;
    localparam int unsigned SEC_BLOCK_MS = 70;
    localparam int unsigned SC_REPORT_MS = 10;
    localparam int unsigned SC_BLOCK_MS = 10;
    localparam int unsigned PRI_REPORT_CYC = PRI_REPORT_MS * CYC_PER_MS;
    localparam int unsigned RELEASE_CYC = RELEASE_MS * CYC_PER_MS;
    localparam int unsigned PRI_BLOCK_CYC = PRI_BLOCK_MS * CYC_PER_MS;
    localparam int unsigned SEC_REPORT_CYC = SEC_REPORT_MS * CYC_PER_MS;
    localparam int unsigned SEC_GAP_CYC = SEC_GAP_MS * CYC_PER_MS;
    localparam int unsigned SEC_BLOCK_CYC = SEC_BLOCK_MS * CYC_PER_MS;
    localparam int unsigned SC_REPORT_CYC = SC_REPORT_MS * CYC_PER_MS;
    localparam int unsigned SC_BLOCK_CYC = SC_BLOCK_MS * CYC_PER_MS;
    localparam logic HALF_BRIDGE_DEFAULT = 1'b1;

    typedef struct packed {
        logic drive_a;
        logic drive_b_en;
        logic pri_uv;
        logic [1:0] sec_uv;
        logic [1:0] short_circuit;
    } gdf_pins_t;

    typedef enum logic [2:0] {S_IDLE, S_REPORT, S_GAP, S_PERSIST, S_RELEASE} gdf_seq_state_t;
endpackage
`default_nettype wire

// ==== rtl/gdf_fault_seq.sv ====
// fault report and input blocking sequencer for one fault source
`timescale 1ns/100ps
`default_nettype none
module gdf_fault_seq #(
    parameter int unsigned REPORT_CYC = gdf_pkg::SC_REPORT_CYC,
    parameter int unsigned GAP_CYC = 0,
    parameter int unsigned RELEASE_CYC = gdf_pkg::RELEASE_CYC,
    parameter int unsigned BLOCK_CYC = gdf_pkg::SC_BLOCK_CYC,
    parameter bit PERSIST = 1'b0
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic fault,
    output logic start,
    output logic report_low,
    output logic blocking
);
    gdf_pkg::gdf_seq_state_t state;
    logic [31:0] cnt;
    logic [31:0] bcnt;
    logic fault_q;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault;
        end
    end

    assign start = (state == gdf_pkg::S_IDLE) && fault && !fault_q;
    assign report_low = (state == gdf_pkg::S_REPORT) || (state == gdf_pkg::S_PERSIST) ||
                        (state == gdf_pkg::S_RELEASE);

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state <= gdf_pkg::S_IDLE;
            cnt <= 32'h0;
        end else begin
            unique case (state)
                gdf_pkg::S_IDLE: begin
                    cnt <= 32'h0;
                    if (start) begin
                        state <= gdf_pkg::S_REPORT;
                    end
                end
                gdf_pkg::S_REPORT: begin
                    if (cnt == REPORT_CYC - 1) begin
                        cnt <= 32'h0;
                        if (GAP_CYC != 0) begin
                            state <= gdf_pkg::S_GAP;
                        end else if (PERSIST && fault) begin
                            state <= gdf_pkg::S_PERSIST;
                        end else begin
                            state <= gdf_pkg::S_IDLE;
                        end
                    end else begin
                        cnt <= cnt + 32'h1;
                    end
                end
                gdf_pkg::S_GAP: begin
                    if (cnt == GAP_CYC - 1) begin
                        cnt <= 32'h0;
                        state <= (PERSIST && fault) ? gdf_pkg::S_PERSIST : gdf_pkg::S_IDLE;
                    end else begin
                        cnt <= cnt + 32'h1;
                    end
                end
                gdf_pkg::S_PERSIST: begin
                    cnt <= 32'h0;
                    if (!fault) begin
                        state <= gdf_pkg::S_RELEASE;
                    end
                end
                gdf_pkg::S_RELEASE: begin
                    if (cnt == RELEASE_CYC - 1) begin
                        cnt <= 32'h0;
                        state <= gdf_pkg::S_IDLE;
                    end else begin
                        cnt <= cnt + 32'h1;
                    end
                end
                default: begin
                    state <= gdf_pkg::S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // blocking lasts while the fault stands and a fixed time after it clears
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            blocking <= 1'b0;
            bcnt <= 32'h0;
        end else if (fault) begin
            blocking <= 1'b1;
            bcnt <= 32'h0;
        end else if (blocking) begin
            if (bcnt == BLOCK_CYC - 1) begin
                blocking <= 1'b0;
            end
            bcnt <= bcnt + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    report_len_a: assert property ((state == gdf_pkg::S_REPORT) && (cnt == REPORT_CYC - 1)
        |=> (state != gdf_pkg::S_REPORT)) else $error("report lasted too long");
    start_report_a: assert property (start |=> report_low [*2])
        else $error("fault report did not start low");
    persist_low_a: assert property ((state == gdf_pkg::S_PERSIST) && fault |=> report_low)
        else $error("persisting fault not held low");
    release_end_a: assert property ((state == gdf_pkg::S_RELEASE) && (cnt == RELEASE_CYC - 1)
        |=> !report_low) else $error("release time wrong");
    block_end_a: assert property (!fault && blocking && (bcnt == BLOCK_CYC - 1)
        |=> !blocking) else $error("blocking did not end on time");
    block_set_a: assert property (fault |=> blocking)
        else $error("fault did not block");
endmodule
`default_nettype wire

// ==== tb/gdf_ctrl_model.sv ====
// controller side model: status line pull-ups and wired fault line
`timescale 1ns/100ps
`default_nettype none
module gdf_ctrl_model (
    input wire logic fault_out_a,
    input wire logic fault_out_a_oen,
    input wire logic fault_out_b,
    input wire logic fault_out_b_oen,
    output logic line_a,
    output logic line_b,
    output logic line_shared
);
    // released line reads the pull-up level
    assign line_a = fault_out_a_oen ? 1'b1 : fault_out_a;
    assign line_b = fault_out_b_oen ? 1'b1 : fault_out_b;
    // both lines tied together
    assign line_shared = line_a & line_b;
endmodule
`default_nettype wire

// ==== tb/gate_drive_input_fault_logic_bench.sv ====
// self-checking bench of the gate drive input and fault logic
`timescale 1ns/100ps
`default_nettype none
module gate_drive_input_fault_logic_bench;
    localparam int DEAD = 500;
    localparam int REL = 80;
    localparam int PRI_REP = 40, PRI_BLK = 80, SEC_REP = 20, SEC_GAP = 100;
    // short-circuit blocking outlasts soft shutdown so the off hold is visible
    localparam int SEC_BLK = 70, SC_REP = 10, SC_BLK = 400;
    localparam int DA = 6, EN = 5, PRI = 4, UVB = 3, UVA = 2, SCA = 0;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    gdf_pkg::gdf_pins_t pins = '0;
    logic [7:0] watch;
    logic [1:0] gd;
    logic on_a, off_a, on_b, off_b, ssd_a, ssd_b, za, zb, fo_a, fo_b, oen_a, oen_b;
    logic line_a, line_b, line_sh, v;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 32'h4fc14cc4;
    int n, m;
    always #4 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////
    gdf_core #(.HALF_BRIDGE(1'b1), .PRI_REPORT_CYC(PRI_REP), .RELEASE_CYC(REL),
        .PRI_BLOCK_CYC(PRI_BLK), .SEC_REPORT_CYC(SEC_REP), .SEC_GAP_CYC(SEC_GAP),
        .SEC_BLOCK_CYC(SEC_BLK), .SC_REPORT_CYC(SC_REP), .SC_BLOCK_CYC(SC_BLK)) dut (
        .clk_sys(clk_sys), .nrst(nrst), .drive_input_a(pins.drive_a),
        .drive_input_b_enable(pins.drive_b_en), .pri_undervoltage(pins.pri_uv),
        .sec_undervoltage_a(pins.sec_uv[0]), .sec_undervoltage_b(pins.sec_uv[1]),
        .short_circuit_a(pins.short_circuit[0]), .short_circuit_b(pins.short_circuit[1]),
        .gate_on_a(on_a), .gate_off_a(off_a), .gate_on_b(on_b), .gate_off_b(off_b),
        .soft_shutdown_a(ssd_a), .soft_shutdown_b(ssd_b), .off_at_zero_a(za),
        .off_at_zero_b(zb), .fault_out_a(fo_a), .fault_out_a_oen(oen_a), .fault_out_b(fo_b),
        .fault_out_b_oen(oen_b));
    gdf_core #(.HALF_BRIDGE(1'b0)) dut_direct (.clk_sys(clk_sys), .nrst(nrst),
        .drive_input_a(pins.drive_a), .drive_input_b_enable(pins.drive_b_en),
        .pri_undervoltage(pins.pri_uv), .sec_undervoltage_a(pins.sec_uv[0]),
        .sec_undervoltage_b(pins.sec_uv[1]), .short_circuit_a(pins.short_circuit[0]),
        .short_circuit_b(pins.short_circuit[1]), .gate_on_a(gd[0]), .gate_off_a(),
        .gate_on_b(gd[1]), .gate_off_b(), .soft_shutdown_a(), .soft_shutdown_b(),
        .off_at_zero_a(), .off_at_zero_b(), .fault_out_a(), .fault_out_a_oen(),
        .fault_out_b(), .fault_out_b_oen());
    gdf_ctrl_model ctrl (.fault_out_a(fo_a), .fault_out_a_oen(oen_a), .fault_out_b(fo_b),
        .fault_out_b_oen(oen_b), .line_a(line_a), .line_b(line_b), .line_shared(line_sh));
    assign watch = {zb, ssd_a, off_b, off_a, line_b, line_a, on_b, on_a};
    ////////////////////////////////////////////////////////////////////////////
    function automatic int exp_low(input int report, input int held, input int rel_cyc);
        return (held < report) ? report : held + rel_cyc;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic near(input string what, input int exp, input int got, input int tol);
        checks++;
        if (got < exp - tol || got > exp + tol) begin
            mismatches++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic poke(input int b, input logic val);
        @(posedge clk_sys);
        pins[b] <= val;
        #1;
    endtask
    // cycles until watched signal reaches val, capped at max
    task automatic wait_for(input int idx, input logic val, input int max, output int k);
        k = 0;
        while (watch[idx] !== val && k < max) begin
            step(1);
            k++;
        end
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_sys);
        #1;
        chk("reset_outs", 11'h298,
            {on_a, off_a, on_b, off_b, ssd_a, za, oen_a, oen_b, fo_a, ssd_b, zb});
        @(posedge clk_sys);
        nrst <= 1'b1;
        done("reset");
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_sys);
            pins.drive_a <= (i == 0) ? 1'b1 : 1'($random(seed));
            pins.drive_b_en <= (i == 0) ? 1'b1 : 1'($random(seed));
            step(5);
            chk("gate_direct", {pins.drive_b_en, pins.drive_a}, gd);
        end
        poke(EN, 1'b0);
        poke(DA, 1'b0);
        step(5);
        chk("direct_gap", 2'h0, gd);
        done("direct");
        poke(EN, 1'b0);
        poke(DA, 1'b1);
        wait_for(0, 1'b1, 600, m);
        chk("enable_low", 600, m);
        chk("enable_low_b", 1'b0, on_b);
        poke(EN, 1'b1);
        wait_for(0, 1'b1, 700, m);
        near("enable_wait", DEAD + 4, m, 2);
        for (int i = 0; i < 8; i++) begin
            v = ~pins.drive_a;
            poke(DA, v);
            step(5);
            chk("off_at_once", 1'b0, v ? on_b : on_a);
            wait_for(v ? 0 : 1, 1'b1, 700, n);
            near("dead_time", DEAD - 1, n, 2);
            step(($random(seed) & 32'h3F) + 1);
        end
        repeat (2) begin
            poke(DA, ~pins.drive_a);
            step(200);
        end
        v = ~pins.drive_a;
        poke(DA, v);
        wait_for(v ? 0 : 1, 1'b1, 700, n);
        near("dead_restart", DEAD + 4, n, 2);
        poke(EN, 1'b0);
        step(5);
        chk("enable_fall", 2'b00, {on_a, on_b});
        done("half_bridge");
        poke(DA, 1'b1);
        poke(EN, 1'b1);
        wait_for(0, 1'b1, 700, m);
        poke(SCA, 1'b1);
        wait_for(2, 1'b0, 10, n);
        chk("sc_soft_off", 5'h11, {ssd_a, on_a, fo_a, line_sh, line_b});
        poke(SCA, 1'b0);
        wait_for(2, 1'b1, 50, m);
        near("sc_report", SC_REP, m + 1, 1);
        step(300);
        chk("sc_hold", 3'b100, {off_a, za, ssd_a});
        done("short_circuit");
        poke(UVB, 1'b1);
        wait_for(3, 1'b0, 10, n);
        chk("uv_soft_off", 1'b1, ssd_b);
        wait_for(3, 1'b1, 50, m);
        near("uv_report", SEC_REP, m, 1);
        wait_for(3, 1'b0, 150, m);
        near("uv_gap", SEC_GAP, m, 1);
        step(200);
        chk("uv_hold", 2'b11, {off_b, zb});
        poke(UVB, 1'b0);
        wait_for(3, 1'b1, 200, m);
        near("uv_release", REL + 3, m, 2);
        poke(UVB, 1'b1);
        wait_for(3, 1'b0, 10, n);
        poke(UVB, 1'b0);
        wait_for(3, 1'b1, 50, m);
        wait_for(3, 1'b0, 150, m);
        chk("uv_stays_high", 150, m);
        done("sec_undervoltage");
        poke(UVA, 1'b1);
        step(300);
        poke(UVA, 1'b0);
        wait_for(0, 1'b1, 200, m);
        near("uv_blocked", SEC_BLK + 3, m, 2);
        chk("uv_resumed", 1'b1, on_a);
        step(200);
        done("sec_blocking");
        poke(PRI, 1'b1);
        wait_for(2, 1'b0, 10, n);
        chk("pri_off", 4'b1100, {off_a, off_b, ssd_a, line_b});
        poke(PRI, 1'b0);
        wait_for(2, 1'b1, 100, m);
        near("pri_report", exp_low(PRI_REP, n + 1, REL), m + 1, 2);
        chk("pri_blocked", 1'b0, on_a);
        wait_for(2, 1'b0, 100, m);
        chk("pri_stays_high", 100, m);
        wait_for(0, 1'b1, 600, m);
        chk("pri_resumed", 1'b1, on_a);
        poke(PRI, 1'b1);
        wait_for(2, 1'b0, 10, n);
        step(150);
        poke(PRI, 1'b0);
        wait_for(2, 1'b1, 200, m);
        near("pri_persist", exp_low(PRI_REP, n + 151, REL), m + 151, 2);
        done("primary");
        conclude();
    end
endmodule
`default_nettype wire
